/* File: bench/core_status_and_prescale_config_regs_tb.sv */
`timescale 1ns/1ps
module core_status_and_prescale_config_regs_tb;
  localparam int CLK_PIN = 2;
  logic sys_clk = 1'h0;
  logic srst, powerUp, wakeReset, wrEn, aluEn, timerClockSourceSelect;
  logic [7:0] wrAddr, wrData, opA, opB, workingReg, statusRd, aluResult;
  logic [4:0] instr;
  logic [8:0] jumpTarget;
  logic [9:0] jumpPc;
  logic [5:0] pinDirectionBits, wakeEnable, pullUpEnable, pinDirEff;
  csp_pkg::csp_alu_e aluOp;
  int fails = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  csp_cpu_model csp_cpu_model_inst (
    .sys_clk(sys_clk), .srst(srst), .powerUp(powerUp),
    .wakeReset(wakeReset), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .opA(opA), .opB(opB), .aluOp(aluOp), .aluEn(aluEn), .instr(instr),
    .workingReg(workingReg), .jumpTarget(jumpTarget),
    .pinDirectionBits(pinDirectionBits));
  csp_status_regs #(.PINS(6), .CLK_PIN(CLK_PIN)) csp_status_regs_inst (
    .sys_clk(sys_clk), .srst(srst), .powerUp(powerUp),
    .wakeReset(wakeReset), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .opA(opA), .opB(opB), .aluOp(aluOp), .aluEn(aluEn),
    .watchdogClearInstr(instr[0]), .sleepInstr(instr[1]),
    .watchdogExpire(instr[2]), .cfgLoadInstr(instr[3]),
    .workingReg(workingReg), .jumpInstr(instr[4]),
    .jumpTarget(jumpTarget), .pinDirectionBits(pinDirectionBits),
    .statusRd(statusRd), .aluResult(aluResult), .jumpPc(jumpPc),
    .timerClockSourceSelect(timerClockSourceSelect),
    .wakeEnable(wakeEnable), .pullUpEnable(pullUpEnable),
    .pinDirEff(pinDirEff));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finalReport;
    $display("comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finalReport;
    end
  end
  // instruction pulses, or a status write when no pulse is given
  task automatic go(input logic [4:0] i, input logic [7:0] d);
    csp_cpu_model_inst.step(i, i == 5'h00, d, csp_pkg::CSP_ALU_NONE,
      8'h00, 8'h00);
  endtask
  function automatic logic [10:0] aluExp(csp_pkg::csp_alu_e op,
    logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    logic dg;
    s = {1'h0, a} + {1'h0, b};
    dg = ({1'h0, a[3:0]} + {1'h0, b[3:0]}) > 5'h0F;
    if (op == csp_pkg::CSP_ALU_SUB) begin
      s = {a >= b, a - b};
      dg = a[3:0] >= b[3:0];
    end
    if (op == csp_pkg::CSP_ALU_ROR) s = {a[0], b[0], a[7:1]};
    if (op == csp_pkg::CSP_ALU_ROL) s = {a[7], a[6:0], b[0]};
    return {s[7:0], s[7:0] == 8'h00, dg, s[8]};
  endfunction
  task automatic testReset;
    csp_cpu_model_inst.rst(1'h1, 1'h0);
    chk(statusRd[7:3], 5'h03);
    chk({timerClockSourceSelect, pinDirEff}, 7'h7F);
  endtask
  task automatic testStatusBits;
    go(5'h02, 8'h00);
    chk(statusRd[4:3], 2'h2);
    go(5'h00, 8'hFF);
    chk(statusRd[6:0], 7'h37);
    go(5'h04, 8'h00);
    chk(statusRd[4:3], 2'h0);
    go(5'h01, 8'h00);
    chk(statusRd[4:3], 2'h3);
    go(5'h04, 8'h00);
    go(5'h00, 8'h00);
    chk(statusRd[6:0], 7'h08);
  endtask
  task automatic testJump;
    for (int p = 0; p < 2; p++) begin
      go(5'h00, {2'h0, p[0], 5'h00});
      csp_cpu_model_inst.step(5'h10, 1'h0, 8'h00, csp_pkg::CSP_ALU_NONE,
        8'hAB, 8'h01);
      chk(jumpPc, {p[0], 9'h1AB});
    end
  endtask
  // each op runs while the status write tries the opposite flags
  task automatic testAlu;
    csp_pkg::csp_alu_e ops [6] = '{csp_pkg::CSP_ALU_ADD,
      csp_pkg::CSP_ALU_ADD, csp_pkg::CSP_ALU_SUB, csp_pkg::CSP_ALU_SUB,
      csp_pkg::CSP_ALU_ROR, csp_pkg::CSP_ALU_ROL};
    logic [7:0] as [6] = '{8'h0F, 8'hF0, 8'h05, 8'h03, 8'h01, 8'h80};
    logic [7:0] bs [6] = '{8'h01, 8'h10, 8'h03, 8'h05, 8'h00, 8'h01};
    logic [10:0] e;
    for (int k = 0; k < 6; k++) begin
      e = aluExp(ops[k], as[k], bs[k]);
      csp_cpu_model_inst.step(5'h00, 1'h1, {5'h00, ~e[2:0]}, ops[k],
        as[k], bs[k]);
      chk(aluResult, e[10:3]);
      chk(statusRd[0], e[0]);
      if (k < 4) chk(statusRd[2:1], e[2:1]);
    end
    // logic op updates zero only; digit carry and carry take the write
    csp_cpu_model_inst.step(5'h00, 1'h1, 8'h03, csp_pkg::CSP_ALU_LOGIC,
      8'h00, 8'hFF);
    chk(aluResult, 8'h00);
    chk(statusRd[2:0], 3'h7);
  endtask
  task automatic testConfig;
    logic [7:0] ws [4] = '{8'h00, 8'hE0, 8'h40, 8'h80};
    logic [5:0] dir;
    dir = 6'h2B;
    for (int k = 0; k < 4; k++) begin
      csp_cpu_model_inst.step(5'h08, 1'h0, 8'h00, csp_pkg::CSP_ALU_NONE,
        ws[k], {2'h0, dir});
      // pin controls follow the loaded config one cycle later
      @(posedge sys_clk);
      #1;
      chk({timerClockSourceSelect, wakeEnable, pullUpEnable, pinDirEff},
        {ws[k][5], dir & {6{~ws[k][7]}}, dir & {6{~ws[k][6]}},
        dir | ({5'h00, ws[k][5]} << CLK_PIN)});
    end
  endtask
  task automatic testWake;
    csp_cpu_model_inst.rst(1'h0, 1'h1);
    chk({statusRd[7:5], timerClockSourceSelect, wakeEnable}, 10'h240);
    csp_cpu_model_inst.rst(1'h0, 1'h0);
    chk({statusRd[7:5], timerClockSourceSelect, pullUpEnable}, 10'h040);
  endtask
  initial begin
    testReset;
    testStatusBits;
    testJump;
    testAlu;
    testConfig;
    testWake;
    finalReport;
  end
endmodule // core_status_and_prescale_config_regs_tb

/* File: bench/csp_cpu_model.sv */
`timescale 1ns/1ps
module csp_cpu_model (
  input wire logic sys_clk,
  output logic srst,
  output logic powerUp,
  output logic wakeReset,
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  output logic [7:0] opA,
  output logic [7:0] opB,
  output csp_pkg::csp_alu_e aluOp,
  output logic aluEn,
  output logic [4:0] instr,
  output logic [7:0] workingReg,
  output logic [8:0] jumpTarget,
  output logic [5:0] pinDirectionBits
);
  initial begin
    {srst, powerUp, wakeReset, wrEn, aluEn, instr} = '0;
    {wrAddr, wrData, opA, opB, workingReg, jumpTarget} = '0;
    pinDirectionBits = 6'h3F;
    aluOp = csp_pkg::CSP_ALU_NONE;
  end
  // one instruction cycle; qualifiers cleared and address, data and operands inverted once released
  task automatic step(input logic [4:0] i, input logic w,
    input logic [7:0] d, input csp_pkg::csp_alu_e op,
    input logic [7:0] a, input logic [7:0] b);
    @(posedge sys_clk);
    instr <= i;
    wrEn <= w;
    wrAddr <= csp_pkg::STATUS_ADDR;
    wrData <= d & 8'hBF;
    aluEn <= (op != csp_pkg::CSP_ALU_NONE);
    aluOp <= op;
    opA <= a;
    opB <= b;
    workingReg <= a;
    jumpTarget <= {b[0], a};
    pinDirectionBits <= b[5:0];
    @(posedge sys_clk);
    {instr, wrEn, aluEn} <= '0;
    wrAddr <= ~wrAddr;
    wrData <= ~wrData;
    opA <= ~opA;
    opB <= ~opB;
    #1;
  endtask
  task automatic rst(input logic pu, input logic wk);
    @(posedge sys_clk);
    srst <= 1'h1;
    powerUp <= pu;
    wakeReset <= wk;
    repeat (4) @(posedge sys_clk);
    {srst, powerUp, wakeReset} <= 3'h0;
    #1;
  endtask
endmodule // csp_cpu_model

/* File: design/csp_flag_alu.sv */
`timescale 1ns/1ps
module csp_flag_alu (
  csp_flag_if.alu f
);
  logic [8:0] sum;
  logic [4:0] low;
  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    f.result = f.opA;
    f.digitCarry = 1'b0;
    f.carry = 1'b0;
    f.zUpd = 1'b0;
    f.digitUpd = 1'b0;
    f.cUpd = 1'b0;
    case (f.op)
      csp_pkg::CSP_ALU_LOGIC: begin
        f.zUpd = 1'b1;
      end
      csp_pkg::CSP_ALU_ADD: begin
        sum = {1'b0, f.opA} + {1'b0, f.opB};
        low = {1'b0, f.opA[3:0]} + {1'b0, f.opB[3:0]};
        f.result = sum[7:0];
        f.digitCarry = low[csp_pkg::NIBBLE];
        f.carry = sum[8];
        f.zUpd = 1'b1;
        f.digitUpd = 1'b1;
        f.cUpd = 1'b1;
      end
      csp_pkg::CSP_ALU_SUB: begin
        sum = {1'b0, f.opA} + {1'b0, ~f.opB} + 9'h001;
        low = {1'b0, f.opA[3:0]} + {1'b0, ~f.opB[3:0]} + 5'h01;
        f.result = sum[7:0];
        f.digitCarry = low[csp_pkg::NIBBLE];
        f.carry = sum[8];
        f.zUpd = 1'b1;
        f.digitUpd = 1'b1;
        f.cUpd = 1'b1;
      end
      csp_pkg::CSP_ALU_ROR: begin
        f.result = {f.opB[0], f.opA[7:1]};
        f.carry = f.opA[0];
        f.cUpd = 1'b1;
      end
      csp_pkg::CSP_ALU_ROL: begin
        f.result = {f.opA[6:0], f.opB[0]};
        f.carry = f.opA[7];
        f.cUpd = 1'b1;
      end
      default: begin
      end
    endcase
    f.zero = (f.result == 8'h00);
  end
endmodule // csp_flag_alu

/* File: design/csp_flag_if.sv */
`timescale 1ns/1ps
interface csp_flag_if;
  logic [7:0] opA;
  logic [7:0] opB;
  csp_pkg::csp_alu_e op;
  logic [7:0] result;
  logic zero;
  logic digitCarry;
  logic carry;
  logic zUpd;
  logic digitUpd;
  logic cUpd;
  modport core (output opA, opB, op, input result, zero, digitCarry,
    carry, zUpd, digitUpd, cUpd);
  modport alu (input opA, opB, op, output result, zero, digitCarry,
    carry, zUpd, digitUpd, cUpd);
endinterface

/* File: design/csp_pkg.sv */
package csp_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam int WAKE_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int PAGE_BIT = 5;
  localparam int TIMEOUT_BIT = 4;
  localparam int PWRDN_BIT = 3;
  localparam int Z_BIT = 2;
  localparam int DIGIT_BIT = 1;
  localparam int C_BIT = 0;
  localparam int PC_PAGE_BIT = 9;
  localparam int CFG_CS_BIT = 5;
  localparam int CFG_PU_BIT = 6;
  localparam int CFG_WU_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] WRITE_MASK = 8'hA7;
  localparam int NIBBLE = 4;
  typedef enum logic [2:0] {
    CSP_ALU_NONE, CSP_ALU_LOGIC, CSP_ALU_ADD, CSP_ALU_SUB, CSP_ALU_ROR,
    CSP_ALU_ROL
  } csp_alu_e;
endpackage

/* File: design/csp_status_regs.sv */
`timescale 1ns/1ps
module csp_status_regs #(
  parameter int PINS = 6,
  parameter int CLK_PIN = 2
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic powerUp,
  input wire logic wakeReset,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire csp_pkg::csp_alu_e aluOp,
  input wire logic aluEn,
  input wire logic watchdogClearInstr,
  input wire logic sleepInstr,
  input wire logic watchdogExpire,
  input wire logic cfgLoadInstr,
  input wire logic [7:0] workingReg,
  input wire logic jumpInstr,
  input wire logic [8:0] jumpTarget,
  input wire logic [PINS-1:0] pinDirectionBits,
  output logic [7:0] statusRd,
  output logic [7:0] aluResult,
  output logic [9:0] jumpPc,
  output logic timerClockSourceSelect,
  output logic [PINS-1:0] wakeEnable,
  output logic [PINS-1:0] pullUpEnable,
  output logic [PINS-1:0] pinDirEff
);
  csp_flag_if f();
  csp_flag_alu uAlu (.f(f));
  logic [7:0] status_r, status_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [9:0] jumpPc_r, jumpPc_nxt;
  logic [PINS-1:0] wake_r, wake_nxt, pull_r, pull_nxt, dir_r, dir_nxt;
  logic [7:0] res_r, res_nxt;
  logic stWr;
  assign f.opA = opA;
  assign f.opB = opB;
  assign f.op = aluEn ? aluOp : csp_pkg::CSP_ALU_NONE;
  assign stWr = wrEn && (wrAddr == csp_pkg::STATUS_ADDR);
  always_comb begin
    status_nxt = status_r;
    if (stWr) begin
      status_nxt = (status_r & ~csp_pkg::WRITE_MASK)
        | (wrData & csp_pkg::WRITE_MASK);
    end
    if (f.zUpd) begin
      status_nxt[csp_pkg::Z_BIT] = f.zero;
    end
    if (f.digitUpd) begin
      status_nxt[csp_pkg::DIGIT_BIT] = f.digitCarry;
    end
    if (f.cUpd) begin
      status_nxt[csp_pkg::C_BIT] = f.carry;
    end
    if (watchdogClearInstr) begin
      status_nxt[csp_pkg::TIMEOUT_BIT] = 1'b1;
      status_nxt[csp_pkg::PWRDN_BIT] = 1'b1;
    end
    if (sleepInstr) begin
      status_nxt[csp_pkg::TIMEOUT_BIT] = 1'b1;
      status_nxt[csp_pkg::PWRDN_BIT] = 1'b0;
    end
    if (watchdogExpire) begin
      status_nxt[csp_pkg::TIMEOUT_BIT] = 1'b0;
    end
    status_nxt[csp_pkg::RSVD_BIT] = 1'b0;
    if (powerUp) begin
      status_nxt = csp_pkg::STATUS_POR;
      status_nxt[csp_pkg::C_BIT] = status_r[csp_pkg::C_BIT];
      status_nxt[csp_pkg::DIGIT_BIT] = status_r[csp_pkg::DIGIT_BIT];
      status_nxt[csp_pkg::Z_BIT] = status_r[csp_pkg::Z_BIT];
    end else if (srst) begin
      status_nxt[csp_pkg::WAKE_BIT] = wakeReset;
      status_nxt[csp_pkg::PAGE_BIT] = 1'b0;
      status_nxt[csp_pkg::RSVD_BIT] = 1'b0;
    end
  end
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfgLoadInstr) begin
      cfg_nxt = workingReg;
    end
    if (srst || powerUp) begin
      cfg_nxt = csp_pkg::CFG_RESET;
    end
  end
  always_comb begin
    jumpPc_nxt = jumpPc_r;
    if (jumpInstr) begin
      jumpPc_nxt = {status_r[csp_pkg::PAGE_BIT], jumpTarget};
    end
    if (srst) begin
      jumpPc_nxt = 10'h000;
    end
  end
  genvar i;
  for (i = 0; i < PINS; i++) begin : g_pin
    always_comb begin
      wake_nxt[i] = pinDirectionBits[i]
        && !cfg_r[csp_pkg::CFG_WU_BIT];
      pull_nxt[i] = pinDirectionBits[i]
        && !cfg_r[csp_pkg::CFG_PU_BIT];
      dir_nxt[i] = pinDirectionBits[i];
      if (i == CLK_PIN && cfg_r[csp_pkg::CFG_CS_BIT]) begin
        dir_nxt[i] = 1'b1;
      end
      if (srst) begin
        wake_nxt[i] = 1'b0;
        pull_nxt[i] = 1'b0;
        dir_nxt[i] = 1'b1;
      end
    end
  end
  always_comb begin
    res_nxt = srst ? 8'h00 : f.result;
  end
  always_ff @(posedge sys_clk) begin
    status_r <= status_nxt;
    cfg_r <= cfg_nxt;
    jumpPc_r <= jumpPc_nxt;
    wake_r <= wake_nxt;
    pull_r <= pull_nxt;
    dir_r <= dir_nxt;
    res_r <= res_nxt;
  end
  assign statusRd = status_r;
  assign aluResult = res_r;
  assign jumpPc = jumpPc_r;
  assign timerClockSourceSelect = cfg_r[csp_pkg::CFG_CS_BIT];
  assign wakeEnable = wake_r;
  assign pullUpEnable = pull_r;
  assign pinDirEff = dir_r;

  sequence s_sleep;
    sleepInstr && !srst && !powerUp && !watchdogExpire;
  endsequence
  property p_sleep_flags;
    @(posedge sys_clk) s_sleep |=> status_r[csp_pkg::TIMEOUT_BIT]
      && !status_r[csp_pkg::PWRDN_BIT];
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep flag update wrong");
  property p_dog_expire;
    @(posedge sys_clk) watchdogExpire && !powerUp
      |=> !status_r[csp_pkg::TIMEOUT_BIT];
  endproperty
  a_dog_expire: assert property (p_dog_expire)
    else $error("time-out not cleared");
  property p_dog_clear;
    @(posedge sys_clk) watchdogClearInstr && !sleepInstr && !watchdogExpire
      |=> status_r[csp_pkg::PWRDN_BIT] && status_r[csp_pkg::TIMEOUT_BIT];
  endproperty
  a_dog_clear: assert property (p_dog_clear)
    else $error("watchdog clear flags wrong");
  property p_tp_protect;
    @(posedge sys_clk) disable iff (srst)
      stWr && !powerUp && !watchdogClearInstr && !sleepInstr
      && !watchdogExpire |=> $stable(status_r[csp_pkg::TIMEOUT_BIT])
      && $stable(status_r[csp_pkg::PWRDN_BIT]);
  endproperty
  a_tp_protect: assert property (p_tp_protect)
    else $error("protected flags changed by write");
  property p_add_carry;
    @(posedge sys_clk) disable iff (srst || powerUp)
      aluEn && aluOp == csp_pkg::CSP_ALU_ADD |=>
      status_r[csp_pkg::C_BIT] == (({1'b0, $past(opA)}
      + {1'b0, $past(opB)}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry wrong");
  property p_zero;
    @(posedge sys_clk) disable iff (srst || powerUp)
      aluEn && f.zUpd |=> status_r[csp_pkg::Z_BIT] == (res_r == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_cfg_reset;
    @(posedge sys_clk) srst |=> cfg_r == csp_pkg::CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config not all ones after reset");
  property p_cfg_load;
    @(posedge sys_clk) disable iff (srst || powerUp)
      cfgLoadInstr |=> cfg_r == $past(workingReg);
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("config load wrong");
  property p_wake_bit;
    @(posedge sys_clk) srst && !powerUp
      |=> status_r[csp_pkg::WAKE_BIT] == $past(wakeReset);
  endproperty
  a_wake_bit: assert property (p_wake_bit)
    else $error("wake reset flag wrong");
  property p_rsvd;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> !status_r[csp_pkg::RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");
  property p_jump;
    @(posedge sys_clk) disable iff (srst)
      jumpInstr |=> jumpPc_r[csp_pkg::PC_PAGE_BIT]
      == $past(status_r[csp_pkg::PAGE_BIT]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump page bit wrong");
  property p_dir_out;
    @(posedge sys_clk) disable iff (srst)
      !pinDirectionBits[0] |=> !wake_r[0] && !pull_r[0];
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("output pin kept wake or pull-up");
  sequence s_add;
    aluEn && aluOp == csp_pkg::CSP_ALU_ADD;
  endsequence
  sequence s_sub;
    aluEn && aluOp == csp_pkg::CSP_ALU_SUB;
  endsequence
  sequence s_ror;
    aluEn && aluOp == csp_pkg::CSP_ALU_ROR;
  endsequence
  sequence s_rol;
    aluEn && aluOp == csp_pkg::CSP_ALU_ROL;
  endsequence
  sequence s_logic;
    aluEn && aluOp == csp_pkg::CSP_ALU_LOGIC;
  endsequence
  property p_add_digit;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_add |=> status_r[csp_pkg::DIGIT_BIT] == (({1'b0, $past(opA[3:0])}
      + {1'b0, $past(opB[3:0])}) > 5'h0F);
  endproperty
  a_add_digit: assert property (p_add_digit)
    else $error("add digit carry wrong");
  property p_sub_digit;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_sub |=> status_r[csp_pkg::DIGIT_BIT]
      == ($past(opA[3:0]) >= $past(opB[3:0]));
  endproperty
  a_sub_digit: assert property (p_sub_digit)
    else $error("subtract digit borrow wrong");
  property p_sub_carry;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_sub |=> status_r[csp_pkg::C_BIT] == ($past(opA) >= $past(opB));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract borrow wrong");
  property p_ror_carry;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_ror |=> status_r[csp_pkg::C_BIT] == $past(opA[0]);
  endproperty
  a_ror_carry: assert property (p_ror_carry)
    else $error("rotate right carry wrong");
  property p_rol_carry;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_rol |=> status_r[csp_pkg::C_BIT] == $past(opA[7]);
  endproperty
  a_rol_carry: assert property (p_rol_carry)
    else $error("rotate left carry wrong");
  property p_logic_zero;
    @(posedge sys_clk) disable iff (srst || powerUp)
      s_logic |=> status_r[csp_pkg::Z_BIT] == ($past(opA) == 8'h00);
  endproperty
  a_logic_zero: assert property (p_logic_zero)
    else $error("logic zero flag wrong");
  property p_power_up;
    @(posedge sys_clk) powerUp |=> status_r[csp_pkg::TIMEOUT_BIT]
      && status_r[csp_pkg::PWRDN_BIT] && !status_r[csp_pkg::WAKE_BIT]
      && !status_r[csp_pkg::PAGE_BIT];
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up status wrong");
  property p_page_write;
    @(posedge sys_clk) disable iff (srst || powerUp)
      stWr |=> status_r[csp_pkg::PAGE_BIT] == $past(wrData[csp_pkg::PAGE_BIT]);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page bit write lost");
  property p_clk_override;
    @(posedge sys_clk) disable iff (srst)
      cfg_r[csp_pkg::CFG_CS_BIT] |=> dir_r[CLK_PIN];
  endproperty
  a_clk_override: assert property (p_clk_override)
    else $error("clock pin direction not overridden");
  property p_pins_input;
    @(posedge sys_clk) disable iff (srst)
      1'b1 |=> ((wake_r | pull_r) & ~$past(pinDirectionBits)) == '0;
  endproperty
  a_pins_input: assert property (p_pins_input)
    else $error("output pin kept wake or pull-up enabled");
  property p_reset_pins;
    @(posedge sys_clk) srst |=> (&dir_r) && !(|wake_r) && !(|pull_r);
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pin controls wrong after reset");
endmodule // csp_status_regs
